//--- hdl/backplane_output_consts.svh
// offsets, field positions, reset values and bus answers of the output bank
// assumes the includer works on a 32-bit AXI4-Lite word map, one word per offset
//
// Behaviour
// - write at 0x8: bits 5..0 become pending bits 13..8 of converter one
// - write at 0x9: byte becomes bits 7..0, completing converter one code
// - high byte waits; converter output changes only on its low byte write
// - write at 0xD: bits 5..0 become pending bits 13..8 of converter two
// - write at 0xE: byte becomes bits 7..0 and converter two updates
// - codes are unsigned 14-bit; 0 most negative, 8192 zero, 16383 full
// - control bit 0 at 0xA held 1 keeps unit in reset; 0 releases
// - on reset both converter codes return to mid-scale 8192
// - bit n at 0xB drives open-drain driver n; 1 pulls line low
// - spare outputs follow the byte last written at 0xC
// - status bit 1 reads 0 while unit reset active, else 1
`ifndef BACKPLANE_OUTPUT_CONSTS_SVH
`define BACKPLANE_OUTPUT_CONSTS_SVH

// ****************************************************************
// register indices; byte address is four times the index
// ****************************************************************
`define IDX_STATUS 4'h2
`define IDX_CONV_A_HIGH 4'h8
`define IDX_CONV_A_LOW 4'h9
`define IDX_UNIT_RESET 4'ha
`define IDX_SINK_DRIVER 4'hb
`define IDX_SPARE_LINES 4'hc
`define IDX_CONV_B_HIGH 4'hd
`define IDX_CONV_B_LOW 4'he

// ****************************************************************
// fields and reset values
// ****************************************************************
`define HIGH_FIELD_MSB 5
`define RESET_BIT 0
`define CONV_WIDTH 14
`define CONV_MID 14'h2000
`define STATUS_FILL 6'h3f
`define BYTE_CLEAR 8'h00

// ****************************************************************
// bus answers
// ****************************************************************
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- hdl/backplane_output_pkg.sv
// types shared by the output register bank and its bench
// assumes the constants header is compiled alongside
package backplane_output_pkg;

    // ****************************************************************
    // stored output state of the bank
    // ****************************************************************
    typedef struct packed {
        logic [13:0] convA;
        logic [13:0] convB;
        logic [5:0] pendA;
        logic [5:0] pendB;
        logic unitReset;
        logic [7:0] sinkCtl;
        logic [7:0] spare;
    } outRegs_t;

    // ****************************************************************
    // converter codes as driven out
    // ****************************************************************
    typedef struct packed {
        logic [13:0] first_converter;
        logic [13:0] second_converter;
    } convCodes_t;

    // ****************************************************************
    // bus slave bookkeeping
    // ****************************************************************
    typedef struct packed {
        logic awHeld;
        logic [3:0] awIdx;
        logic awOk;
        logic wHeld;
        logic [7:0] wByte;
        logic wLane;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } busRegs_t;

endpackage : backplane_output_pkg

//--- hdl/backplane_output_register_bank.sv
// write-only output register bank of the backplane, with its status word
// assumes an AXI4-Lite master on the same clock and a synchronous low reset
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "backplane_output_consts.svh"

module backplane_output_register_bank #(
    parameter int ADDR_WIDTH = 8
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic ce,
    // axi4-lite slave
    input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // backplane side
    input wire logic busyLine_b,
    output backplane_output_pkg::convCodes_t convCodes,
    output logic unitResetOut,
    output logic [7:0] sinkOut,
    output logic [7:0] sinkOe,
    output logic [7:0] spare_output_line
);
    import backplane_output_pkg::*;

    // ****************************************************************
    // address decode
    // ****************************************************************

    // word index of a byte address; bits above the map are dropped here and checked by inMap
    function automatic logic [3:0] wordIndex(input logic [ADDR_WIDTH-1:0] addr);
        wordIndex = addr[5:2];
    endfunction : wordIndex

    // true only for aligned addresses that land inside the sixteen words
    function automatic logic inMap(input logic [ADDR_WIDTH-1:0] addr);
        inMap = (addr[1:0] == 2'h0) && (addr[ADDR_WIDTH-1:6] == '0);
    endfunction : inMap

    // ****************************************************************
    // state
    // ****************************************************************
    outRegs_t st;
    outRegs_t next_st;
    busRegs_t bus;
    busRegs_t next_bus;
    logic busyMeta;
    logic busySync;
    logic [3:0] rdIdx;
    logic [3:0] wrIdx;

    // ****************************************************************
    // busy line synchroniser
    // ****************************************************************

    // the line comes from any slot, so it is foreign to this clock
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            busyMeta <= 1'b1;
            busySync <= 1'b1;
        end else if (ce) begin
            busyMeta <= busyLine_b;
            busySync <= busyMeta;
        end
    end

    // ****************************************************************
    // next-state logic
    // ****************************************************************

    // one write and one read are handled at a time; writes act once both halves are in
    always_comb begin
        next_st = st;
        next_bus = bus;
        wrIdx = bus.awIdx;
        rdIdx = wordIndex(s_axi_araddr);
        // address and data are taken independently, in either order
        if (s_axi_awvalid && s_axi_awready) begin
            next_bus.awHeld = 1'b1;
            next_bus.awIdx = wordIndex(s_axi_awaddr);
            next_bus.awOk = inMap(s_axi_awaddr);
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_bus.wHeld = 1'b1;
            next_bus.wByte = s_axi_wdata[7:0];
            next_bus.wLane = s_axi_wstrb[0];
        end
        // both halves held: perform the write and raise the response
        if (bus.awHeld && bus.wHeld && !bus.bvalid) begin
            next_bus.awHeld = 1'b0;
            next_bus.wHeld = 1'b0;
            next_bus.bvalid = 1'b1;
            next_bus.bresp = bus.awOk ? `RESP_OKAY : `RESP_SLVERR;
            // a cleared lane-0 strobe leaves the byte register untouched
            if (bus.awOk && bus.wLane) begin
                case (wrIdx)
                    `IDX_CONV_A_HIGH: begin
                        next_st.pendA = bus.wByte[`HIGH_FIELD_MSB:0];
                    end
                    `IDX_CONV_A_LOW: begin
                        next_st.convA = {st.pendA, bus.wByte};
                    end
                    `IDX_UNIT_RESET: begin
                        next_st.unitReset = bus.wByte[`RESET_BIT];
                    end
                    `IDX_SINK_DRIVER: begin
                        next_st.sinkCtl = bus.wByte;
                    end
                    `IDX_SPARE_LINES: begin
                        next_st.spare = bus.wByte;
                    end
                    `IDX_CONV_B_HIGH: begin
                        next_st.pendB = bus.wByte[`HIGH_FIELD_MSB:0];
                    end
                    `IDX_CONV_B_LOW: begin
                        next_st.convB = {st.pendB, bus.wByte};
                    end
                    default: begin
                        next_st = next_st;
                    end
                endcase
            end
        end
        if (bus.bvalid && s_axi_bready) begin
            next_bus.bvalid = 1'b0;
        end
        // unit reset holds converters at zero volts and drivers off
        if (next_st.unitReset) begin
            next_st.convA = `CONV_MID;
            next_st.convB = `CONV_MID;
            next_st.pendA = '0;
            next_st.pendB = '0;
            next_st.sinkCtl = `BYTE_CLEAR;
        end
        // reads only sample state; nothing stored changes on them
        if (s_axi_arvalid && s_axi_arready) begin
            next_bus.rvalid = 1'b1;
            next_bus.rresp = `RESP_OKAY;
            next_bus.rdata = 32'h0000_0000;
            if (!inMap(s_axi_araddr)) begin
                next_bus.rresp = `RESP_SLVERR;
            end else if (rdIdx == `IDX_STATUS) begin
                next_bus.rdata[7:0] = {`STATUS_FILL, ~st.unitReset, busySync};
            end
        end else if (bus.rvalid && s_axi_rready) begin
            next_bus.rvalid = 1'b0;
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************

    // clock enable low freezes every flip-flop of the bank
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            st.convA <= `CONV_MID;
            st.convB <= `CONV_MID;
            st.pendA <= '0;
            st.pendB <= '0;
            st.unitReset <= 1'b0;
            st.sinkCtl <= `BYTE_CLEAR;
            st.spare <= `BYTE_CLEAR;
            bus <= '0;
        end else if (ce) begin
            st <= next_st;
            bus <= next_bus;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************

    // ready terms stay low while a half is held or an answer waits
    // ce low hides every handshake term: a frozen slave neither drops a request nor answers twice
    assign s_axi_awready = ce && !bus.awHeld && !bus.bvalid;
    assign s_axi_wready = ce && !bus.wHeld && !bus.bvalid;
    assign s_axi_arready = ce && !bus.rvalid;
    assign s_axi_bvalid = ce && bus.bvalid;
    assign s_axi_bresp = bus.bresp;
    assign s_axi_rvalid = ce && bus.rvalid;
    assign s_axi_rdata = bus.rdata;
    assign s_axi_rresp = bus.rresp;

    // open drain: driver on means enable high with a low level
    assign sinkOe = st.sinkCtl;
    assign sinkOut = `BYTE_CLEAR;
    assign spare_output_line = st.spare;
    assign unitResetOut = st.unitReset;
    assign convCodes.first_converter = st.convA;
    assign convCodes.second_converter = st.convB;

endmodule : backplane_output_register_bank

//--- verif/backplane_output_monitor.sv
// assertion monitor for the output register bank, bound to its ports
// assumes it sees the ports of the bank, clock enable and write strobes included
`timescale 1ns/1ps
module backplane_output_monitor
    import backplane_output_pkg::*;
#(
    parameter int ADDR_WIDTH = 8
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_rvalid,
    input wire backplane_output_pkg::convCodes_t convCodes,
    input wire logic unitResetOut,
    input wire logic [7:0] sinkOe,
    input wire logic [7:0] spare_output_line
);
    logic [ADDR_WIDTH-1:0] wa;
    logic [7:0] wd;
    logic wl;
    // ********
    // last write taken, held until the next one
    // ********
    always_ff @(posedge clock) begin
        if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
        if (s_axi_wvalid && s_axi_wready) {wl, wd} <= {s_axi_wstrb[0], s_axi_wdata[7:0]};
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    // reset values, then outputs tied to the write that the response closes
    mid_reset_a: assert property ($rose(rst_b) |-> convCodes == {2{14'h2000}})
        else $error("codes not mid-scale after reset");
    out_clear_a: assert property ($rose(rst_b) |-> sinkOe == 8'h00 && spare_output_line == 8'h00)
        else $error("driver or spare lines not clear after reset");
    code_hold_a: assert property ($past(rst_b) && !$rose(s_axi_bvalid) |-> $stable(convCodes))
        else $error("code moved without a write");
    pend_wait_a: assert property ($rose(s_axi_bvalid) && wa == 8'h20 |-> $stable(convCodes))
        else $error("high byte moved the output");
    a_low_a: assert property ($rose(s_axi_bvalid) && wl && wa == 8'h24 && !unitResetOut
        |-> convCodes.first_converter[7:0] == wd) else $error("first low byte wrong");
    b_low_a: assert property ($rose(s_axi_bvalid) && wl && wa == 8'h38 && !unitResetOut
        |-> convCodes.second_converter[7:0] == wd) else $error("second low byte wrong");
    sink_map_a: assert property ($rose(s_axi_bvalid) && wl && wa == 8'h2c && !unitResetOut
        |-> sinkOe == wd) else $error("driver enables wrong");
    spare_map_a: assert property ($rose(s_axi_bvalid) && wl && wa == 8'h30
        |-> spare_output_line == wd) else $error("spare lines wrong");
    reset_ctl_a: assert property ($rose(s_axi_bvalid) && wl && wa == 8'h28
        |-> unitResetOut == wd[0]) else $error("unit reset bit wrong");
    // a write whose lane-0 strobe is clear must leave the codes, driver enables and spare lines as they were
    lane_off_a: assert property ($rose(s_axi_bvalid) && !wl
        |-> $stable(convCodes) && $stable(sinkOe) && $stable(spare_output_line))
        else $error("write without lane 0 moved outputs");
    // clock enable low freezes the bank
    freeze_hold_a: assert property (!ce |=> $stable(convCodes) && $stable(sinkOe)
        && $stable(spare_output_line) && $stable(unitResetOut)) else $error("outputs moved while frozen");
    unit_hold_a: assert property (unitResetOut |-> sinkOe == 8'h00 && convCodes == {2{14'h2000}})
        else $error("outputs not held in unit reset");
    read_quiet_a: assert property ($rose(s_axi_rvalid)
        |-> $stable(convCodes) && $stable(sinkOe)) else $error("read disturbed outputs");
    cover property ($rose(s_axi_bvalid) && wa == 8'h24);
    cover property ($rose(unitResetOut));
    cover property ($rose(s_axi_rvalid));
endmodule : backplane_output_monitor
bind backplane_output_register_bank backplane_output_monitor #(.ADDR_WIDTH(ADDR_WIDTH)) monitor_inst (.*);

//--- verif/test_backplane_output_register_bank.sv
// self-checking bench for the output register bank
// assumes the bank is an AXI4-Lite slave with byte address four times the index
`timescale 1ns/1ps
module test_backplane_output_register_bank;
    import backplane_output_pkg::*;
    logic clock = 1'h0, rst_b = 1'h0, ce = 1'h1, busyLine_b = 1'h1, ur;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, sinkOut, sinkOe, spare_output_line, es, eo;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
    logic [3:0] s_axi_wstrb = 4'h1;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, unitResetOut;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    convCodes_t convCodes;
    logic [13:0] ea, eb;
    logic [5:0] pa, pb;
    int error_cnt = 0, n_compared = 0;
    logic [3:0] ri;
    // 5 ms of unit reset at 100 ns a cycle
    localparam int HOLD_CYCLES = 50000;
    backplane_output_register_bank backplane_output_register_bank_inst (.*);
    // 10 MHz system clock
    always #50 clock = ~clock;
    task automatic close_out();
        $display("compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : close_out
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // ********
    // one bus transfer; ready sampled at the falling edge, so no race at the rising one
    // ********
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        logic fin, ta, tw, tr;
        @(posedge clock);
        if (wr) {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, 24'h0, d, 3'h7};
        else {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        fin = 1'h0;
        for (int i = 0; i < 50 && !fin; i++) begin
            @(negedge clock);
            fin = wr ? s_axi_bvalid : s_axi_rvalid;
            {ta, tw, tr, rdat} = {s_axi_awready, s_axi_wready, s_axi_arready, s_axi_rdata};
            rsp = wr ? s_axi_bresp : s_axi_rresp;
            @(posedge clock);
            if (ta) s_axi_awvalid <= 1'h0;
            if (tw) s_axi_wvalid <= 1'h0;
            if (tr) s_axi_arvalid <= 1'h0;
        end
        {s_axi_bready, s_axi_rready} <= 2'h0;
        if (!fin) begin
            chk(64'h0, 64'h1); // hang cut short
            close_out();
        end
    endtask : bus
    function automatic logic [63:0] outs();
        return {19'h0, ea, eb, es, eo, ur};
    endfunction : outs
    task automatic look();
        @(negedge clock);
        chk({19'h0, convCodes, sinkOe, spare_output_line, unitResetOut}, outs());
        chk(sinkOut, 8'h00);
    endtask : look
    task automatic mclr();
        {ea, eb, pa, pb, es, eo, ur} = {14'h2000, 14'h2000, 29'h0};
    endtask : mclr
    // write through the bus and step the expected state; unit reset discards and clears
    task automatic put(input logic [3:0] idx, input logic [7:0] d);
        bus(1'h1, {2'h0, idx, 2'h0}, d);
        chk(rsp, 2'h0);
        case (idx)
            4'h8: pa = d[5:0];
            4'h9: ea = {pa, d};
            4'ha: ur = d[0];
            4'hb: es = d;
            4'hc: eo = d;
            4'hd: pb = d[5:0];
            4'he: eb = {pb, d};
            default: ;
        endcase
        if (ur) {ea, eb, pa, pb, es} = {14'h2000, 14'h2000, 20'h0};
        look();
    endtask : put
    task automatic stat();
        bus(1'h0, 8'h08, 8'h00);
        chk(rdat, {24'h0, 6'h3f, ~ur, busyLine_b});
    endtask : stat
    initial begin
        void'($urandom(32'hea4d6d5b));
        mclr();
        repeat (4) @(posedge clock);
        rst_b <= 1'h1;
        look();
        // full-scale and zero codes, a mid high byte left pending, then a low byte with no new high byte
        put(4'h8, 8'hff);
        put(4'h9, 8'hff);
        put(4'hd, 8'h00);
        put(4'he, 8'h00);
        put(4'hd, 8'h20);
        put(4'h9, 8'h5a);
        stat();
        // busy line low well before the next status read passes its synchroniser
        busyLine_b <= 1'h0;
        put(4'ha, 8'h01);
        stat();
        put(4'h8, 8'h11);
        put(4'h9, 8'h22);
        put(4'hb, 8'hf0);
        repeat (HOLD_CYCLES) @(posedge clock);
        busyLine_b <= 1'h1;
        put(4'ha, 8'h00);
        stat();
        // random traffic; a low byte always follows a fresh high byte
        repeat (60) begin
            ri = 4'h8 + 4'($urandom % 6);
            if (ri >= 4'ha) ri = ri + 4'h1; // unit reset stays with the timed case
            if (ri == 4'h9 || ri == 4'he) put(ri - 4'h1, 8'($urandom));
            put(ri, 8'($urandom));
        end
        // clock enable low: a pending write waits and nothing moves until it rises
        @(posedge clock);
        ce <= 1'h0;
        fork
            put(4'hc, 8'h3c);
            begin
                repeat (4) @(posedge clock);
                look();
                chk(s_axi_bvalid, 1'h0);
                @(posedge clock);
                ce <= 1'h1;
            end
        join
        // reads of write-only places return zero and leave everything as it was
        for (int i = 8; i < 15; i++) begin
            bus(1'h0, 8'(i * 4), 8'h00);
            chk(rdat, 32'h0);
            look();
        end
        // beyond the map and unaligned: refused, nothing moves
        bus(1'h1, 8'h40, 8'h55);
        chk(rsp, 2'h2);
        bus(1'h1, 8'h25, 8'h55);
        chk(rsp, 2'h2);
        // lane 0 strobe clear: answered, but the spare lines keep their byte
        s_axi_wstrb <= 4'h0;
        bus(1'h1, 8'h30, 8'h99);
        chk(rsp, 2'h0);
        s_axi_wstrb <= 4'h1;
        look();
        @(posedge clock);
        rst_b <= 1'h0;
        repeat (4) @(posedge clock);
        rst_b <= 1'h1;
        mclr();
        look();
        close_out();
    end
endmodule : test_backplane_output_register_bank
